// ### logic/fzc_defines.vh
// Constants for the fan zone and coefficient register bank.
// Assumes an 8-bit register port from the management bus front end.
`ifndef FZC_DEFINES_VH
`define FZC_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FZC_ADDR_HOTTEST 8'h78
`define FZC_ADDR_COEF_ONE 8'h79
`define FZC_ADDR_COEF_TWO 8'h7a
`define FZC_ADDR_COEF_THREE 8'h7b
`define FZC_ADDR_ZONE_ONE 8'h7c
`define FZC_ADDR_COEF_SEL_LO 8'h7e
`define FZC_ADDR_COEF_SEL_HI 8'h7f
`define FZC_ADDR_TEMP_BASE 8'h20

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define FZC_RESET_BYTE 8'h00
`define FZC_ZONE_MAX 4'h0
`define FZC_ZONE_LAST 4'ha
`define FZC_SPIN_NONE 3'h0
`define FZC_NUM_CH 10

// ----------------------------------------
// Spin-up times in ms and cycles at 125 MHz
// ----------------------------------------
`define FZC_CLK_KHZ 125000
`define FZC_SPIN_MS_1 100
`define FZC_SPIN_MS_2 250
`define FZC_SPIN_MS_3 400
`define FZC_SPIN_MS_4 667
`define FZC_SPIN_MS_5 1000
`define FZC_SPIN_MS_6 2000
`define FZC_SPIN_MS_7 4000

`endif

// ### logic/fzc_regs.v
// Fan zone select and sensor coefficient option registers.
// Assumes the bus front end gives a one-cycle write strobe with address and data.
`timescale 1ns/1ps
`include "fzc_defines.vh"

// Summary of operation
// R1 - Gain bits 1:0 in 0x7a bits 7:6
// R2 - Offset bits 8:3 in 0x7a bits 5:0
// R3 - Offset bits 2:0 in 0x7b bits 7:5
// R4 - Spin-up code selects start duration
// R5 - Fan 1 zone in 0x7c upper nibble
// R6 - Codes 1 to 10 pick channels 1-10
// R7 - Fan 2 zone in lower nibble
// R8 - All four registers reset to zero
// R9 - Gain bits 9:2 held at 0x79
// R10 - 0x78 reads hottest sensor temperature
// R11 - Select bit picks optional coefficients
// R12 - Reserved zone codes fall back to hottest
module fzc_regs #(
  parameter [31:0] SPIN_MS_1 = `FZC_SPIN_MS_1,
  parameter [31:0] SPIN_MS_7 = `FZC_SPIN_MS_7
) (
  // Clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // Register port
  input wire wr_en_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  // Sensor readings, channel n in bits 8n-1:8n-8
  input wire [8*`FZC_NUM_CH-1:0] temps_i,
  input wire [`FZC_NUM_CH-1:0] fan_start_i,
  // Decoded configuration
  output reg [9:0] sensor_gain_coef_o,
  output reg [8:0] sensor_offset_coef_o,
  output reg [9:0] use_opt_coef_o,
  output reg [2:0] auto_fan_start_time_o,
  output reg [7:0] hottest_reading_reg_o,
  output reg [7:0] first_fan_temp_o,
  output reg [7:0] second_fan_temp_o,
  output reg spin_active_o
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [7:0] coef_option_one;
  reg [7:0] coef_option_two;
  reg [7:0] coef_option_three;
  reg [7:0] fan_zone_select_one;
  reg [9:0] coef_sel;
  reg [31:0] spin_cnt;
  reg [7:0] next_rdata;
  reg [31:0] spin_len;
  wire [7:0] run_max [0:`FZC_NUM_CH];
  wire [7:0] next_max = run_max[`FZC_NUM_CH];

  wire [3:0] first_fan_zone_sel = fan_zone_select_one[7:4]; // R5
  wire [3:0] second_fan_zone_sel = fan_zone_select_one[3:0]; // R7

  // Zone code to temperature; reserved codes use the hottest reading
  function [7:0] zone_temp;
    input [3:0] code;
    input [8*`FZC_NUM_CH-1:0] temps;
    input [7:0] hottest;
    begin
      if (code == `FZC_ZONE_MAX || code > `FZC_ZONE_LAST) begin // R12
        zone_temp = hottest;
      end else begin
        zone_temp = temps[8*(code-4'h1) +: 8]; // R6
      end
    end
  endfunction

  // ----------------------------------------
  // Hottest reading: running maximum over the channels
  // ----------------------------------------
  assign run_max[0] = `FZC_RESET_BYTE;

  genvar g;
  generate
    for (g = 0; g < `FZC_NUM_CH; g = g + 1) begin : g_max
      wire [7:0] reading = temps_i[8*g +: 8];
      assign run_max[g+1] = (reading > run_max[g]) ? reading : run_max[g]; // R10
    end
  endgenerate

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      coef_option_one <= `FZC_RESET_BYTE; // R8
      coef_option_two <= `FZC_RESET_BYTE; // R8
      coef_option_three <= `FZC_RESET_BYTE; // R8
      fan_zone_select_one <= `FZC_RESET_BYTE; // R8
      coef_sel <= 10'h000;
    end else if (wr_en_i) begin
      // Unmapped addresses leave every register unchanged
      case (addr_i)
        `FZC_ADDR_COEF_ONE: coef_option_one <= wdata_i; // R9
        `FZC_ADDR_COEF_TWO: coef_option_two <= wdata_i; // R1
        `FZC_ADDR_COEF_THREE: coef_option_three <= wdata_i; // R3
        `FZC_ADDR_ZONE_ONE: fan_zone_select_one <= wdata_i; // R5
        `FZC_ADDR_COEF_SEL_LO: coef_sel[9:2] <= wdata_i; // R11
        `FZC_ADDR_COEF_SEL_HI: coef_sel[1:0] <= wdata_i[7:6]; // R11
        default: coef_sel <= coef_sel;
      endcase
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    case (addr_i)
      `FZC_ADDR_HOTTEST: next_rdata = hottest_reading_reg_o; // R10
      `FZC_ADDR_COEF_ONE: next_rdata = coef_option_one;
      `FZC_ADDR_COEF_TWO: next_rdata = coef_option_two;
      `FZC_ADDR_COEF_THREE: next_rdata = coef_option_three;
      `FZC_ADDR_ZONE_ONE: next_rdata = fan_zone_select_one;
      `FZC_ADDR_COEF_SEL_LO: next_rdata = coef_sel[9:2];
      `FZC_ADDR_COEF_SEL_HI: next_rdata = {coef_sel[1:0], 6'h00};
      default: begin
        if (addr_i >= `FZC_ADDR_TEMP_BASE && addr_i < `FZC_ADDR_TEMP_BASE + `FZC_NUM_CH) begin
          next_rdata = temps_i[8*(addr_i-`FZC_ADDR_TEMP_BASE) +: 8];
        end else begin
          next_rdata = 8'h00;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Spin-up length in clock cycles
  // ----------------------------------------
  // Code zero gives no spin-up window at all
  always @* begin
    case (coef_option_three[2:0]) // R4
      3'h1: spin_len = SPIN_MS_1 * (`FZC_CLK_KHZ);
      3'h2: spin_len = `FZC_SPIN_MS_2 * (`FZC_CLK_KHZ);
      3'h3: spin_len = `FZC_SPIN_MS_3 * (`FZC_CLK_KHZ);
      3'h4: spin_len = `FZC_SPIN_MS_4 * (`FZC_CLK_KHZ);
      3'h5: spin_len = `FZC_SPIN_MS_5 * (`FZC_CLK_KHZ);
      3'h6: spin_len = `FZC_SPIN_MS_6 * (`FZC_CLK_KHZ);
      3'h7: spin_len = SPIN_MS_7 * (`FZC_CLK_KHZ);
      default: spin_len = 32'h0;
    endcase
  end

  // ----------------------------------------
  // Read data register
  // ----------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= `FZC_RESET_BYTE;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------
  // Decoded coefficient and spin-up fields
  // ----------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sensor_gain_coef_o <= 10'h000;
      sensor_offset_coef_o <= 9'h000;
      use_opt_coef_o <= 10'h000;
      auto_fan_start_time_o <= `FZC_SPIN_NONE;
    end else begin
      sensor_gain_coef_o <= {coef_option_one, coef_option_two[7:6]}; // R1
      sensor_offset_coef_o <= {coef_option_two[5:0], coef_option_three[7:5]}; // R2
      use_opt_coef_o <= coef_sel; // R11
      auto_fan_start_time_o <= coef_option_three[2:0]; // R4
    end
  end

  // ----------------------------------------
  // Hottest reading register
  // ----------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hottest_reading_reg_o <= `FZC_RESET_BYTE;
    end else begin
      hottest_reading_reg_o <= next_max; // R10
    end
  end

  // ----------------------------------------
  // Controlling temperature per fan
  // ----------------------------------------
  // Code zero follows the registered hottest reading, so it lags one cycle
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      first_fan_temp_o <= `FZC_RESET_BYTE;
      second_fan_temp_o <= `FZC_RESET_BYTE;
    end else begin
      first_fan_temp_o <= zone_temp(first_fan_zone_sel, temps_i, hottest_reading_reg_o); // R5
      second_fan_temp_o <= zone_temp(second_fan_zone_sel, temps_i, hottest_reading_reg_o); // R7
    end
  end

  // ----------------------------------------
  // Spin-up timer
  // ----------------------------------------
  // A held start request keeps reloading, so the window ends after release
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      spin_active_o <= 1'b0;
      spin_cnt <= 32'h0;
    end else begin
      if (|fan_start_i && spin_len != 32'h0) begin // R4
        spin_cnt <= spin_len;
        spin_active_o <= 1'b1;
      end else if (spin_cnt > 32'h1) begin
        spin_cnt <= spin_cnt - 32'h1;
      end else begin
        spin_cnt <= 32'h0;
        spin_active_o <= 1'b0;
      end
    end
  end

endmodule // fzc_regs

// ### bench/fzc_regs_asserts.sv
// Checker for the fan zone and coefficient register bank.
// Assumes outputs follow a write two edges later.
`timescale 1ns/1ps
module fzc_regs_asserts (
  // Watched ports
  input wire clk_i, arst_n_i, wr_en_i,
  input wire [7:0] addr_i, wdata_i, rdata_o, first_fan_temp_o, second_fan_temp_o,
  input wire [79:0] temps_i,
  input wire [9:0] sensor_gain_coef_o,
  input wire [8:0] sensor_offset_coef_o,
  input wire [2:0] auto_fan_start_time_o,
  input wire [9:0] use_opt_coef_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire w7a = wr_en_i && addr_i == 8'h7a;
  wire w7b = wr_en_i && addr_i == 8'h7b;
  wire w7c = wr_en_i && addr_i == 8'h7c;
  AST_GAIN_LO: assert property (w7a |-> ##2 sensor_gain_coef_o[1:0] == $past(wdata_i[7:6], 2))
    else $error("gain low bits wrong");
  AST_OFFS_HI: assert property (w7a |-> ##2 sensor_offset_coef_o[8:3] == $past(wdata_i[5:0], 2))
    else $error("offset high bits wrong");
  AST_OFFS_LO: assert property (w7b |-> ##2 sensor_offset_coef_o[2:0] == $past(wdata_i[7:5], 2))
    else $error("offset low bits wrong");
  AST_SPIN: assert property (w7b |-> ##2 auto_fan_start_time_o == $past(wdata_i[2:0], 2))
    else $error("spin-up code wrong");
  AST_GAIN_HI: assert property (wr_en_i && addr_i == 8'h79 |-> ##2 sensor_gain_coef_o[9:2] == $past(wdata_i, 2))
    else $error("gain high bits wrong");
  AST_OPT_SEL: assert property (wr_en_i && addr_i == 8'h7e |->
    ##2 use_opt_coef_o[9:2] == $past(wdata_i, 2))
    else $error("coefficient select bits wrong");
  AST_RESET: assert property ($rose(arst_n_i) |-> !sensor_gain_coef_o && !sensor_offset_coef_o && !auto_fan_start_time_o)
    else $error("outputs not clear after reset");
  AST_READ: assert property (w7b ##1 addr_i == 8'h7b |=> rdata_o == $past(wdata_i, 2))
    else $error("read back differs");
  AST_FAN1: assert property (w7c && wdata_i[7:4] inside {[1:10]} ##1 ($stable(temps_i) && !wr_en_i)[*2] |-> first_fan_temp_o == temps_i[8*$past(wdata_i[7:4], 2)-8 +: 8])
    else $error("fan one source wrong");
  AST_FAN2: assert property (w7c && wdata_i[3:0] inside {[1:10]} ##1 ($stable(temps_i) && !wr_en_i)[*2] |-> second_fan_temp_o == temps_i[8*$past(wdata_i[3:0], 2)-8 +: 8])
    else $error("fan two source wrong");
endmodule // fzc_regs_asserts
bind fzc_regs fzc_regs_asserts i_chk (.*);

// ### bench/fzc_host.sv
// Host model driving the register port of the fan zone bank.
// Assumes read data is registered one edge after the address.
`timescale 1ns/1ps
module fzc_host (
  input wire clk_i,
  input wire [7:0] rdata_i,
  output reg wr_en_o = 0,
  output reg [7:0] addr_o = 0,
  output reg [7:0] wdata_o = 0
);
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk_i);
    #1 wr_en_o = 1;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #1 wr_en_o = 0;
    wdata_o = ~d;
  endtask
  task rd(input [7:0] a, output [7:0] q);
    @(posedge clk_i);
    #1 addr_o = a;
    @(posedge clk_i);
    #1 q = rdata_i;
  endtask
endmodule // fzc_host

// ### bench/test_fan_zone_coef_registers.sv
// Testbench for the fan zone and coefficient register bank.
// Assumes the host model issues all register traffic.
`timescale 1ns/1ps
module test_fan_zone_coef_registers;
  reg clk_i = 0;
  reg arst_n_i = 0;
  reg [79:0] temps_i = 0;
  reg [7:0] q;
  reg [9:0] fan_start = 0;
  wire [9:0] opt_sel;
  wire spin_act;
  wire wr_en;
  wire [7:0] addr, wdata, rdata, fan1_t, fan2_t, hot;
  wire [9:0] gain;
  wire [8:0] offs;
  wire [2:0] spin;
  integer failures = 0;
  integer n_checks = 0;
  integer n;
  always #4 clk_i = ~clk_i;
  fzc_host i_host (.clk_i(clk_i), .rdata_i(rdata), .wr_en_o(wr_en), .addr_o(addr), .wdata_o(wdata));
  fzc_regs i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .wr_en_i(wr_en), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata), .temps_i(temps_i), .fan_start_i(fan_start),
    .sensor_gain_coef_o(gain), .sensor_offset_coef_o(offs), .use_opt_coef_o(opt_sel),
    .auto_fan_start_time_o(spin), .hottest_reading_reg_o(hot), .first_fan_temp_o(fan1_t),
    .second_fan_temp_o(fan2_t), .spin_active_o(spin_act));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #40000;
    failures++;
    final_report;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    #1 arst_n_i = 1;
    for (n = 1; n <= 10; n++) temps_i[8*n-8 +: 8] = 8'h10 + n;
    for (n = 0; n < 3; n++) begin
      i_host.rd(8'h7a + n, q);
      chk(q, 16'h0000);
    end
    @(posedge clk_i);
    #1 fan_start = 10'h004;
    @(posedge clk_i);
    #1 fan_start = 10'h000;
    chk(spin_act, 16'h0000);
    i_host.wr(8'h79, 8'h96);
    i_host.wr(8'h7a, 8'hc5);
    i_host.wr(8'h7b, 8'ha3);
    i_host.rd(8'h7a, q);
    chk(q, 16'h00c5);
    i_host.rd(8'h7b, q);
    chk(q, 16'h00a3);
    chk(gain, 16'h025b);
    chk(offs, 16'h002d);
    chk(spin, 16'h0003);
    @(posedge clk_i);
    #1 fan_start = 10'h200;
    @(posedge clk_i);
    #1 fan_start = 10'h000;
    chk(spin_act, 16'h0001);
    repeat (100) @(posedge clk_i);
    #1 chk(spin_act, 16'h0001);
    i_host.wr(8'h7e, 8'h5a);
    i_host.wr(8'h7f, 8'hff);
    i_host.rd(8'h7f, q);
    chk(q, 16'h00c0);
    i_host.rd(8'h7e, q);
    chk(q, 16'h005a);
    chk(opt_sel, 16'h016b);
    i_host.rd(8'h79, q);
    chk(q, 16'h0096);
    i_host.rd(8'h78, q);
    chk(q, 16'h001a);
    i_host.rd(8'h22, q);
    chk(q, 16'h0013);
    for (n = 1; n <= 10; n++) begin
      q = 11 - n;
      i_host.wr(8'h7c, {n[3:0], q[3:0]});
      repeat (3) @(posedge clk_i);
      #1;
      chk(fan1_t, 8'h10 + n);
      chk(fan2_t, 8'h1b - n);
    end
    i_host.wr(8'h7c, 8'h00);
    repeat (4) @(posedge clk_i);
    #1;
    chk(hot, 16'h001a);
    chk(fan1_t, 16'h001a);
    chk(fan2_t, 16'h001a);
    final_report;
  end
endmodule // test_fan_zone_coef_registers
